/* File: rtl/qdl_host.sv */
// host that drives the quad converter latch strobes
`include "qdl_map.svh"
module qdl_host
    import qdl_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_start,
    input  wire qdl_op_t                i_op,
    input  wire logic [`QDL_CH_W-1:0]   i_ch,
    input  wire logic [`QDL_DATA_W-1:0] i_word0,
    input  wire logic [`QDL_DATA_W-1:0] i_word1,
    input  wire logic [`QDL_DATA_W-1:0] i_word2,
    input  wire logic [`QDL_DATA_W-1:0] i_word3,
    input  wire logic                   i_zero,
    output logic                        o_busy,
    output logic                        o_done,
    output logic                        o_cs_n,
    output logic                        o_latch_strobe_n,
    output logic                        o_range_word_select_n,
    output logic                        o_passthrough_n,
    output logic                        o_readback_n,
    output logic                        o_reset_n,
    output logic                        o_channel_addr0,
    output logic                        o_channel_addr1,
    output logic [`QDL_DATA_W-1:0]      o_data
);
    qdl_state_t                state_r;
    qdl_op_t                   op_r;
    logic [`QDL_CH_W-1:0]      ch_r;
    logic                      multi_r;
    logic                      long_cs_r;
    logic [`QDL_DATA_W-1:0]    word_r [4];
    logic                      tm_load;
    logic [`QDL_CNT_W-1:0]     tm_count;
    logic                      tm_done;

    qdl_timer u_timer (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_load    (tm_load),
        .i_count   (tm_count),
        .o_done    (tm_done)
    );

    ////////////////////////////////////////////////////////////////////
    // phase timing
    always_comb begin
        tm_load  = 1'b0;
        tm_count = '0;
        unique case (state_r)
            QDL_IDLE: begin
                tm_load  = i_start && i_rstn;
                // preload times the cs low width, the others the strobe low
                tm_count = (i_op == QDL_OP_PRELOAD) ?
                           `QDL_CNT_W'(`QDL_TCW_CYC) :
                           `QDL_CNT_W'(`QDL_TLW_CYC);
            end
            QDL_LS_LOW: begin
                tm_load  = tm_done;
                tm_count = `QDL_CNT_W'(`QDL_TCH_CYC);
            end
            QDL_CS_HIGH_WAIT: begin
                tm_load  = tm_done;
                tm_count = `QDL_CNT_W'(`QDL_THOLD_CYC);
            end
            QDL_SETUP, QDL_HOLD: begin
                tm_load  = 1'b0;
                tm_count = '0;
            end
            QDL_NEXT: begin
                // rearm strobe low time for the next channel of a walk
                tm_load  = multi_r && (ch_r != `QDL_CH_LAST);
                tm_count = `QDL_CNT_W'(`QDL_TLW_CYC);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // word capture
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            op_r      <= QDL_OP_PRELOAD;
            multi_r   <= 1'b0;
            long_cs_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                word_r[i] <= '0;
            end
        end else if (state_r == QDL_IDLE && i_start) begin
            op_r      <= i_op;
            // walk all four channels in turn
            multi_r   <= (i_op == QDL_OP_SEQ_UPDATE);
            long_cs_r <= 1'b0;
            word_r[0] <= i_word0;
            word_r[1] <= i_word1;
            word_r[2] <= i_word2;
            word_r[3] <= i_word3;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_r <= QDL_IDLE;
            ch_r    <= '0;
        end else begin
            unique case (state_r)
                QDL_IDLE: begin
                    if (i_start) begin
                        state_r <= QDL_SETUP;
                        ch_r    <= (i_op == QDL_OP_SEQ_UPDATE) ? '0 : i_ch;
                    end
                end
                QDL_SETUP: state_r <= QDL_LS_LOW;
                QDL_LS_LOW: begin
                    if (tm_done) begin
                        state_r <= QDL_CS_HIGH_WAIT;
                    end
                end
                QDL_CS_HIGH_WAIT: begin
                    if (tm_done) begin
                        state_r <= QDL_HOLD;
                    end
                end
                QDL_HOLD: state_r <= QDL_NEXT;
                QDL_NEXT: begin
                    if (multi_r && ch_r != `QDL_CH_LAST) begin
                        ch_r    <= ch_r + 1'b1;
                        state_r <= QDL_SETUP;
                    end else begin
                        state_r <= QDL_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_cs_n           <= 1'b1;
            o_latch_strobe_n <= 1'b1;
            o_channel_addr0  <= 1'b0;
            o_channel_addr1  <= 1'b0;
            o_data           <= '0;
        end else begin
            unique case (state_r)
                QDL_IDLE: begin
                    o_cs_n           <= 1'b1;
                    o_latch_strobe_n <= 1'b1;
                end
                QDL_SETUP: begin
                    // strobe falls with cs except on update-all, where it stays high through the same strobe low wait
                    o_cs_n           <= 1'b0;
                    o_latch_strobe_n <= (op_r == QDL_OP_UPDATE_ALL);
                    o_channel_addr0  <= ch_r[0];
                    o_channel_addr1  <= ch_r[1];
                    o_data           <= word_r[ch_r];
                end
                QDL_LS_LOW: begin
                    if (tm_done) begin
                        if (op_r == QDL_OP_PRELOAD) begin
                            o_cs_n <= 1'b1;
                        end else begin
                            o_latch_strobe_n <= 1'b1;
                        end
                    end
                end
                QDL_CS_HIGH_WAIT: begin
                    if (tm_done) begin
                        o_cs_n           <= 1'b1;
                        o_latch_strobe_n <= 1'b1;
                    end
                end
                QDL_HOLD, QDL_NEXT: begin
                    o_cs_n           <= 1'b1;
                    o_latch_strobe_n <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // static controls and status
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_range_word_select_n <= 1'b1;
            o_passthrough_n       <= 1'b1;
            o_readback_n          <= 1'b1;
            o_reset_n             <= 1'b0;
            o_busy                <= 1'b0;
            o_done                <= 1'b0;
        end else begin
            o_range_word_select_n <= 1'b1;
            o_passthrough_n       <= 1'b1;
            o_readback_n          <= 1'b1;
            o_reset_n             <= !i_zero;
            o_busy                <= (state_r != QDL_IDLE) || i_start;
            o_done                <= (state_r == QDL_NEXT) &&
                                     !(multi_r && ch_r != `QDL_CH_LAST);
        end
    end
endmodule // qdl_host

/* File: pkg/qdl_map.svh */
// strobe timing counts and field widths for the quad latch host
`ifndef QDL_MAP_SVH
`define QDL_MAP_SVH
`define QDL_CLK_NS      40
`define QDL_DATA_W      12
`define QDL_CH_W        2
`define QDL_CH_LAST     2'h3
// times in ns, least times rounded up to whole clocks
`define QDL_TLW_NS      80
`define QDL_TCH_NS      50
`define QDL_TCW_NS      100
`define QDL_TLH_NS      15
`define QDL_THOLD_NS    15
`define QDL_TLW_CYC     ((`QDL_TLW_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_TCH_CYC     ((`QDL_TCH_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_TCW_CYC     ((`QDL_TCW_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_TLH_CYC     ((`QDL_TLH_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_THOLD_CYC   ((`QDL_THOLD_NS + `QDL_CLK_NS - 1) / `QDL_CLK_NS)
`define QDL_CNT_W       3
`endif

/* File: pkg/qdl_pkg.sv */
// types for the quad latch host
package qdl_pkg;
    typedef enum logic [1:0] {
        QDL_OP_PRELOAD,
        QDL_OP_LOAD_UPDATE,
        QDL_OP_UPDATE_ALL,
        QDL_OP_SEQ_UPDATE
    } qdl_op_t;
    typedef enum logic [2:0] {
        QDL_IDLE,
        QDL_SETUP,
        QDL_LS_LOW,
        QDL_CS_HIGH_WAIT,
        QDL_HOLD,
        QDL_NEXT
    } qdl_state_t;
endpackage

/* File: rtl/qdl_timer.sv */
// down counter for strobe phase lengths
`include "qdl_map.svh"
module qdl_timer
    import qdl_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_load,
    input  wire logic [`QDL_CNT_W-1:0] i_count,
    output logic                       o_done
);
    logic [`QDL_CNT_W-1:0] cnt_r;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // plain count test: the caller reloads on done, so no load term here
    assign o_done = (cnt_r == '0);
endmodule // qdl_timer

/* File: verif/qdl_checker.sv */
// strobe ordering assertions for the quad latch host
`include "qdl_map.svh"
module qdl_checker (
    input wire logic                   i_sys_clk,
    input wire logic                   i_rstn,
    input wire logic                   i_start,
    input wire logic                   i_zero,
    input wire logic                   o_busy,
    input wire logic                   o_cs_n,
    input wire logic                   o_latch_strobe_n,
    input wire logic                   o_range_word_select_n,
    input wire logic                   o_passthrough_n,
    input wire logic                   o_readback_n,
    input wire logic                   o_reset_n,
    input wire logic [`QDL_DATA_W-1:0] o_data
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_cs_release;
        ##[1:8] $rose(o_cs_n);
    endsequence
    a_strobe_with_cs: assert property (
        $fell(o_latch_strobe_n) |-> $fell(o_cs_n))
        else $error("strobe fell apart from cs");
    a_no_same_edge: assert property (
        $rose(o_latch_strobe_n) |-> !$rose(o_cs_n))
        else $error("strobe and cs rose together");
    a_ctrl_held_high: assert property (
        !o_cs_n |-> o_range_word_select_n && o_passthrough_n && o_readback_n)
        else $error("control pin low during cs");
    a_data_hold: assert property (
        $rose(o_cs_n) |=> $stable(o_data))
        else $error("data moved right after cs rise");
    a_strobe_low_width: assert property (
        $fell(o_latch_strobe_n) |=> !o_latch_strobe_n)
        else $error("strobe low too short");
    a_cs_hold_strobe: assert property (
        $rose(o_latch_strobe_n) && !o_cs_n |=> !o_cs_n)
        else $error("cs rose too soon after strobe");
    a_cs_low_width: assert property (
        $fell(o_cs_n) |=> !o_cs_n [*2])
        else $error("cs low too short");
    a_start_to_cs: assert property (
        i_start && !o_busy |-> ##[2:4] $fell(o_cs_n))
        else $error("no cs after start");
    a_zero_reset: assert property (
        i_zero |=> !o_reset_n)
        else $error("zero request not on reset pin");
    a_update_no_strobe: assert property (
        $fell(o_cs_n) && o_latch_strobe_n |->
            o_latch_strobe_n throughout s_cs_release)
        else $error("strobe moved in update cycle");
endmodule // qdl_checker
bind qdl_host qdl_checker qdl_checker_inst (.i_sys_clk, .i_rstn, .i_start,
    .i_zero, .o_busy, .o_cs_n, .o_latch_strobe_n, .o_range_word_select_n,
    .o_passthrough_n, .o_readback_n, .o_reset_n, .o_data);

/* File: verif/qdl_dev_model.sv */
// behavioural quad converter with two latch ranks per channel
`include "qdl_map.svh"
module qdl_dev_model (
    input  wire logic                   i_cs_n,
    input  wire logic                   i_latch_strobe_n,
    input  wire logic                   i_ctrl_n,
    input  wire logic                   i_reset_n,
    input  wire logic [`QDL_CH_W-1:0]   i_ch,
    input  wire logic [`QDL_DATA_W-1:0] i_data,
    output logic      [`QDL_DATA_W-1:0] o_first [4],
    output logic      [`QDL_DATA_W-1:0] o_code [4]
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`QDL_DATA_W-1:0] second [4] = '{default: '0};
    initial o_first = '{default: '0};
    // short wait lets same-edge data settle
    always @(negedge i_cs_n or posedge i_latch_strobe_n) begin
        #1;
        if (i_reset_n && i_ctrl_n && !i_cs_n) begin
            if (i_latch_strobe_n)
                second = o_first;
            else
                o_first[i_ch] = i_data;
        end
    end
    always_comb
        for (int k = 0; k < 4; k++)
            o_code[k] = i_reset_n ? second[k] : '0;
endmodule // qdl_dev_model

/* File: verif/quad_dac_double_rank_latch_control_tb.sv */
// self-checking bench for the quad latch host
`include "qdl_map.svh"
module quad_dac_double_rank_latch_control_tb import qdl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk = 0, i_rstn = 0, i_start = 0, i_zero = 0;
    qdl_op_t i_op = QDL_OP_PRELOAD;
    logic [`QDL_CH_W-1:0] i_ch = '0;
    logic [`QDL_DATA_W-1:0] w [4] = '{default: '0};
    logic o_busy, o_done, o_cs_n, o_latch_strobe_n, o_range_word_select_n;
    logic o_passthrough_n, o_readback_n, o_reset_n;
    logic o_channel_addr0, o_channel_addr1;
    logic [`QDL_DATA_W-1:0] o_data, first [4], code [4];
    int fail_count = 0, cmp_count = 0, cyc = 0;
    int exp_first [4] = '{default: 0}, exp_code [4] = '{default: 0};
    always #20 i_sys_clk = ~i_sys_clk;
    qdl_host qdl_host_inst (.i_sys_clk, .i_rstn, .i_start, .i_op, .i_ch,
        .i_word0(w[0]), .i_word1(w[1]), .i_word2(w[2]), .i_word3(w[3]),
        .i_zero, .o_busy, .o_done, .o_cs_n, .o_latch_strobe_n,
        .o_range_word_select_n, .o_passthrough_n, .o_readback_n,
        .o_reset_n, .o_channel_addr0, .o_channel_addr1, .o_data);
    qdl_dev_model qdl_dev_model_inst (.i_cs_n(o_cs_n),
        .i_latch_strobe_n(o_latch_strobe_n),
        .i_ctrl_n(o_range_word_select_n & o_passthrough_n & o_readback_n),
        .i_reset_n(o_reset_n), .i_ch({o_channel_addr1, o_channel_addr0}),
        .i_data(o_data), .o_first(first), .o_code(code));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [`QDL_DATA_W-1:0] seen, input int exp);
        cmp_count++;
        if (seen !== `QDL_DATA_W'(exp)) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic run(input qdl_op_t op, input int ch);
        @(negedge i_sys_clk);
        foreach (w[k]) w[k] = `QDL_DATA_W'($urandom);
        i_op = op;
        i_ch = ch[1:0];
        i_start = 1;
        @(negedge i_sys_clk);
        i_start = 0;
        while (o_done !== 1'b1) @(negedge i_sys_clk);
        if (!i_zero) begin
            if (op == QDL_OP_SEQ_UPDATE)
                foreach (w[k]) exp_first[k] = w[k];
            else if (op != QDL_OP_UPDATE_ALL)
                exp_first[ch] = w[ch];
            if (op != QDL_OP_PRELOAD)
                exp_code = exp_first;
        end
        foreach (code[k]) begin
            check(code[k], i_zero ? 0 : exp_code[k]);
            check(first[k], exp_first[k]);
        end
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        void'($urandom(87));
        repeat (2) @(negedge i_sys_clk);
        i_rstn = 1;
        foreach (code[k]) check(code[k], 0);
        for (int ch = 0; ch < 4; ch++) run(QDL_OP_LOAD_UPDATE, ch);
        for (int ch = 3; ch >= 0; ch--) run(QDL_OP_PRELOAD, ch);
        run(QDL_OP_UPDATE_ALL, 1);
        run(QDL_OP_SEQ_UPDATE, 0);
        repeat (10) run(qdl_op_t'($urandom_range(3)), $urandom_range(3));
        i_zero = 1;
        run(QDL_OP_LOAD_UPDATE, 2);
        run(QDL_OP_PRELOAD, 0);
        i_zero = 0;
        run(QDL_OP_UPDATE_ALL, 3);
        run(QDL_OP_PRELOAD, 2);
        run(QDL_OP_UPDATE_ALL, 0);
        test_done();
    end
endmodule // quad_dac_double_rank_latch_control_tb
